// [logic/pm_event_pkg.sv]
package pm_event_pkg;

  // register offsets (byte addresses, one aligned word each)
  localparam logic [7:0] OFS_FLAGS = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h08;
  localparam logic [7:0] OFS_INT_STATUS = 8'h0c;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;

  // flag register bit positions
  localparam int BIT_BM_FLAG = 4;
  localparam int BIT_GBL_FLAG = 5;
  localparam int BIT_PB_FLAG = 8;
  localparam int BIT_OVR_FLAG = 11;

  // enable register: power button event enable
  localparam int BIT_PB_ENABLE = 8;

  // control register: routing select and firmware release strobe
  localparam int BIT_ROUTE_SEL = 0;
  localparam int BIT_FW_RELEASE = 1;

  // interrupt status / mask layout
  localparam int INT_W = 4;
  localparam int IBIT_PB_SET = 0;
  localparam int IBIT_OVERRIDE = 1;
  localparam int IBIT_GBL_SET = 2;
  localparam int IBIT_BM_SET = 3;

  // reset values
  localparam logic RST_FLAG = 1'b0;
  localparam logic RST_ENABLE = 1'b0;
  localparam logic RST_ROUTE = 1'b0;
  localparam logic [INT_W-1:0] RST_INT = 4'h0;

  // timing: long press before forced power off
  localparam int CLK_HZ = 20_000_000;
  localparam int PB_OVERRIDE_S = 4;
  localparam int PB_CNT_W = 27;
  localparam logic [PB_CNT_W-1:0] PB_OVERRIDE_CYCLES = PB_CNT_W'(PB_OVERRIDE_S * CLK_HZ);

  // source counts
  localparam int NUM_PCI_REQ = 6;
  localparam int NUM_INT_MASTERS = 4;
  localparam int NUM_USB = 3;
  localparam int USB_PORTS = 2;
  localparam int NUM_AUDIO_DMA = 4;

  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  // one usb host controller's state, as seen by activity detection
  typedef struct packed {
    logic global_suspend;
    logic [USB_PORTS-1:0] port_suspended;
    logic run;
  } usb_status_s;

endpackage : pm_event_pkg

// [logic/pm_event_status_bits.sv]
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - button low sets power button flag until override
// - long press: clear flag, override, S5
// - writing one clears power button flag
// - button flag survives port hard reset
// - awake: flag and enable raise SCI/SMI
// - sleeping: flag and enable raise wake
// - firmware release sets attention flag, SCI
// - bus master request sets activity flag
// - PCI, internal, graphics, USB show activity
// - USB active: running, unsuspended, port awake
// - each USB controller feeds its own term
// - IDE engine active while start bit set
// - activity flag never wakes or raises SCI/SMI
// - writing one clears bus master flag
// - audio link activity sets activity flag
module pm_event_status_bits #(
  parameter logic [pm_event_pkg::PB_CNT_W-1:0] OVERRIDE_CYCLES =
    pm_event_pkg::PB_OVERRIDE_CYCLES,
  parameter int NUM_PCI_REQ = pm_event_pkg::NUM_PCI_REQ,
  parameter int NUM_INT_MASTERS = pm_event_pkg::NUM_INT_MASTERS,
  parameter int NUM_USB = pm_event_pkg::NUM_USB,
  parameter int NUM_AUDIO_DMA = pm_event_pkg::NUM_AUDIO_DMA
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hard_reset_cf9,
  input pm_event_pkg::reg_req_s reg_req,
  output logic [31:0] reg_rdata,
  input wire logic power_button_input_n,
  input wire logic system_sleeping,
  input wire logic [NUM_PCI_REQ-1:0] pci_req_n,
  input wire logic [NUM_INT_MASTERS-1:0] internal_master_req,
  input wire logic graphics_port_busy_n,
  input pm_event_pkg::usb_status_s [NUM_USB-1:0] usb_status,
  input wire logic ide_bus_master_engine_start,
  input wire logic [NUM_AUDIO_DMA-1:0] audio_dma_run,
  output logic sci,
  output logic system_management_interrupt_n,
  output logic wake_event,
  output logic s5_request,
  output logic wake_button_only,
  output logic irq
);

  // address match for one register
  function automatic logic addr_is(input pm_event_pkg::reg_req_s r, input logic [7:0] ofs);
    addr_is = (r.addr == ofs);
  endfunction : addr_is

  // pin synchronisers: first stage is read only by second stage
  logic pb_meta_q;
  logic pb_sync_q;
  logic gfx_meta_q;
  logic gfx_sync_q;
  logic [NUM_PCI_REQ-1:0] pci_meta_q;
  logic [NUM_PCI_REQ-1:0] pci_sync_q;

  // state registers
  logic [pm_event_pkg::PB_CNT_W-1:0] pb_cnt_q;
  logic [pm_event_pkg::PB_CNT_W-1:0] pb_cnt_d;
  logic ovr_hold_q; // latched after override until release
  logic ovr_hold_d;
  logic pb_flag_q;
  logic pb_flag_d;
  logic ovr_flag_q;
  logic ovr_flag_d;
  logic gbl_flag_q;
  logic gbl_flag_d;
  logic bm_flag_q;
  logic bm_flag_d;
  logic pb_en_q; // power_button_event_enable
  logic route_sel_q; // interrupt_route_select: 1 = SCI
  logic s5_req_q;
  logic wake_only_q;
  logic wake_only_d;
  logic sleeping_q;
  logic [pm_event_pkg::INT_W-1:0] int_sts_q;
  logic [pm_event_pkg::INT_W-1:0] int_sts_d;
  logic [pm_event_pkg::INT_W-1:0] int_mask_q;
  logic [31:0] rdata_q;

  // bus decode
  wire wr_flags = reg_req.wr && addr_is(reg_req, pm_event_pkg::OFS_FLAGS);
  wire wr_enable = reg_req.wr && addr_is(reg_req, pm_event_pkg::OFS_ENABLE);
  wire wr_control = reg_req.wr && addr_is(reg_req, pm_event_pkg::OFS_CONTROL);
  wire wr_int_mask = reg_req.wr && addr_is(reg_req, pm_event_pkg::OFS_INT_MASK);
  wire rd_int_sts = reg_req.rd && addr_is(reg_req, pm_event_pkg::OFS_INT_STATUS);

  // write-one-clear strobes and the firmware release strobe
  wire clr_pb = wr_flags && reg_req.wdata[pm_event_pkg::BIT_PB_FLAG];
  wire clr_ovr = wr_flags && reg_req.wdata[pm_event_pkg::BIT_OVR_FLAG];
  wire clr_gbl = wr_flags && reg_req.wdata[pm_event_pkg::BIT_GBL_FLAG];
  wire clr_bm = wr_flags && reg_req.wdata[pm_event_pkg::BIT_BM_FLAG];
  wire fw_release = wr_control && reg_req.wdata[pm_event_pkg::BIT_FW_RELEASE];

  // power button after synchronising
  wire btn_low = !pb_sync_q;
  // exact compare: the counter is held at zero while the hold is set
  wire override_hit = btn_low && !ovr_hold_q && (pb_cnt_q == OVERRIDE_CYCLES);
  wire pb_set = btn_low && !ovr_hold_q && !override_hit;

  // per-controller usb activity
  logic [NUM_USB-1:0] usb_active;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_USB; gi++)
    begin : g_usb
      assign usb_active[gi] = !usb_status[gi].global_suspend &&
        !(&usb_status[gi].port_suspended) && usb_status[gi].run;
    end
  endgenerate

  // bus master activity sources
  wire pci_active = !(&pci_sync_q);
  wire int_active = |internal_master_req;
  wire gfx_active = !gfx_sync_q;
  wire usb_any = |usb_active;
  wire audio_active = |audio_dma_run;
  wire bm_active = pci_active || int_active || gfx_active || usb_any ||
    ide_bus_master_engine_start || audio_active;

  // event routing; bus master flag takes no part here
  // button event only when enabled
  wire pb_event = pb_flag_q && pb_en_q;
  wire awake_pb = !system_sleeping && pb_event;
  assign sci = (awake_pb && route_sel_q) || gbl_flag_q;
  assign system_management_interrupt_n = !(awake_pb && !route_sel_q);
  assign wake_event = system_sleeping && pb_event;

  // long press counter; held at zero once the override fired
  assign pb_cnt_d = (!btn_low || ovr_hold_q) ? '0 : pb_cnt_q + 1'b1;
  assign ovr_hold_d = override_hit || (ovr_hold_q && btn_low);

  // flag next values, set wins over software clear
  assign pb_flag_d = pb_set || (pb_flag_q && !clr_pb && !override_hit);
  assign ovr_flag_d = override_hit || (ovr_flag_q && !clr_ovr);
  assign gbl_flag_d = fw_release || (gbl_flag_q && !clr_gbl);
  assign bm_flag_d = bm_active || (bm_flag_q && !clr_bm);

  // wake restricted to the button after an override, until back awake
  assign wake_only_d = override_hit || (wake_only_q && !(sleeping_q && !system_sleeping));

  // sticky interrupt events, read of the status clears them
  wire [pm_event_pkg::INT_W-1:0] int_ev = {
    bm_flag_d && !bm_flag_q,
    fw_release,
    override_hit,
    pb_set && !pb_flag_q
  };
  assign int_sts_d = int_ev | (int_sts_q & {pm_event_pkg::INT_W{!rd_int_sts}});
  // level interrupt, masked per bit
  assign irq = |(int_sts_q & int_mask_q);

  // read data selection
  logic [31:0] flags_word;
  logic [31:0] enable_word;
  logic [31:0] control_word;
  logic [31:0] rd_mux;
  always_comb
  begin
    flags_word = '0;
    flags_word[pm_event_pkg::BIT_PB_FLAG] = pb_flag_q;
    flags_word[pm_event_pkg::BIT_OVR_FLAG] = ovr_flag_q;
    flags_word[pm_event_pkg::BIT_GBL_FLAG] = gbl_flag_q;
    flags_word[pm_event_pkg::BIT_BM_FLAG] = bm_flag_q;
    enable_word = '0;
    enable_word[pm_event_pkg::BIT_PB_ENABLE] = pb_en_q;
    control_word = '0;
    control_word[pm_event_pkg::BIT_ROUTE_SEL] = route_sel_q;
  end
  assign rd_mux =
    addr_is(reg_req, pm_event_pkg::OFS_FLAGS) ? flags_word :
    addr_is(reg_req, pm_event_pkg::OFS_ENABLE) ? enable_word :
    addr_is(reg_req, pm_event_pkg::OFS_CONTROL) ? control_word :
    addr_is(reg_req, pm_event_pkg::OFS_INT_STATUS) ? {28'h0000000, int_sts_q} :
    addr_is(reg_req, pm_event_pkg::OFS_INT_MASK) ? {28'h0000000, int_mask_q} :
    32'h00000000; // unmapped reads zero
  // registered outputs
  assign reg_rdata = rdata_q;
  assign s5_request = s5_req_q;
  assign wake_button_only = wake_only_q;

  // synchronisers for outside pins
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      // idle level of every pin, so no false edge
      pb_meta_q <= 1'b1;
      pb_sync_q <= 1'b1;
      gfx_meta_q <= 1'b1;
      gfx_sync_q <= 1'b1;
      pci_meta_q <= '1;
      pci_sync_q <= '1;
    end
    else
    begin
      // two stages per pin, only the second is read
      pb_meta_q <= power_button_input_n;
      pb_sync_q <= pb_meta_q;
      gfx_meta_q <= graphics_port_busy_n;
      gfx_sync_q <= gfx_meta_q;
      pci_meta_q <= pci_req_n;
      pci_sync_q <= pci_meta_q;
    end
  end

  // status flags: only the well reset clears them
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      // well reset only; the port hard reset never reaches here
      pb_flag_q <= pm_event_pkg::RST_FLAG;
      ovr_flag_q <= pm_event_pkg::RST_FLAG;
      gbl_flag_q <= pm_event_pkg::RST_FLAG;
      bm_flag_q <= pm_event_pkg::RST_FLAG;
      pb_en_q <= pm_event_pkg::RST_ENABLE;
    end
    else
    begin
      // next values already hold set-wins-over-clear
      pb_flag_q <= pb_flag_d;
      ovr_flag_q <= ovr_flag_d;
      gbl_flag_q <= gbl_flag_d;
      bm_flag_q <= bm_flag_d;
      // enable is software owned and kept by the port hard reset
      if (wr_enable)
        pb_en_q <= reg_req.wdata[pm_event_pkg::BIT_PB_ENABLE];
    end
  end

  // long press tracking and power-off request
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      // no press in progress
      pb_cnt_q <= '0;
      ovr_hold_q <= 1'b0;
      s5_req_q <= 1'b0;
      wake_only_q <= 1'b0;
      sleeping_q <= 1'b0;
    end
    else
    begin
      // counter, hold latch and power-off pulse step together
      pb_cnt_q <= pb_cnt_d;
      ovr_hold_q <= ovr_hold_d;
      s5_req_q <= override_hit;
      wake_only_q <= wake_only_d;
      sleeping_q <= system_sleeping;
    end
  end

  // core-side control, cleared also by the port hard reset
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      route_sel_q <= pm_event_pkg::RST_ROUTE;
      int_sts_q <= pm_event_pkg::RST_INT;
      int_mask_q <= pm_event_pkg::RST_INT;
    end
    // port hard reset: routing and interrupt bookkeeping only
    else if (hard_reset_cf9)
    begin
      route_sel_q <= pm_event_pkg::RST_ROUTE;
      int_sts_q <= pm_event_pkg::RST_INT;
      int_mask_q <= pm_event_pkg::RST_INT;
    end
    else
    begin
      int_sts_q <= int_sts_d;
      // route select is the only stored control bit
      if (wr_control)
        route_sel_q <= reg_req.wdata[pm_event_pkg::BIT_ROUTE_SEL];
      // mask takes the low bits of the word
      if (wr_int_mask)
        int_mask_q <= reg_req.wdata[pm_event_pkg::INT_W-1:0];
    end
  end

  // read data, valid the cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rdata_q <= '0;
    // capture the addressed word
    else if (reg_req.rd)
      rdata_q <= rd_mux;
    else
      rdata_q <= '0;
  end

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // button flag and long press
  a_button_sets_flag: assert property (pb_set |=> pb_flag_q)
    else $error("button press did not set flag");
  a_override_effects: assert property (override_hit |=> !pb_flag_q && ovr_flag_q &&
    s5_request && wake_button_only)
    else $error("override did not clear flag and request power off");
  a_override_timing: assert property (override_hit |-> pb_cnt_q == OVERRIDE_CYCLES &&
    $past(btn_low))
    else $error("override fired at wrong count");
  a_pb_write_clear: assert property (clr_pb && !pb_set |=> !pb_flag_q)
    else $error("write one did not clear button flag");
  a_pb_write_zero: assert property (wr_flags && !reg_req.wdata[pm_event_pkg::BIT_PB_FLAG] &&
    pb_flag_q && !override_hit |=> pb_flag_q)
    else $error("write zero changed button flag");
  a_cf9_keeps_flag: assert property (hard_reset_cf9 && pb_flag_q && !clr_pb &&
    !override_hit |=> pb_flag_q)
    else $error("hard reset lost button flag");
  // event routing
  a_awake_routing: assert property (!system_sleeping && pb_flag_q && pb_en_q |->
    (route_sel_q ? sci : !system_management_interrupt_n))
    else $error("awake button event not routed");
  a_sleep_wake: assert property (system_sleeping && pb_flag_q && pb_en_q |-> wake_event &&
    system_management_interrupt_n)
    else $error("sleeping button event did not wake");
  // firmware attention
  a_release_sci: assert property (fw_release |=> gbl_flag_q && sci)
    else $error("firmware release did not raise attention");
  // bus master activity
  a_bm_sources: assert property (bm_active |=> bm_flag_q)
    else $error("activity did not set bus master flag");
  a_usb_to_flag: assert property (usb_any |=> bm_flag_q)
    else $error("usb activity lost");
  a_bm_silent: assert property (!pb_event && !gbl_flag_q |-> !sci &&
    system_management_interrupt_n && !wake_event)
    else $error("bus master flag caused an event");
  a_bm_write_clear: assert property (clr_bm && !bm_active |=> !bm_flag_q)
    else $error("write one did not clear bus master flag");
  a_audio_sets: assert property (audio_active |=> bm_flag_q)
    else $error("audio activity did not set flag");
  // pulse is one cycle: the hold latch blocks a second hit
  a_s5_single: assert property (s5_request |=> !s5_request)
    else $error("power-off request longer than one cycle");
  // no re-arm while the same press is still held
  a_hold_no_rearm: assert property (ovr_hold_q |=> !pb_flag_q)
    else $error("button flag set again during held press");
  // port hard reset clears routing and interrupt bookkeeping
  a_cf9_clears_ctrl: assert property (hard_reset_cf9 |=> !route_sel_q &&
    int_sts_q == '0 && int_mask_q == '0)
    else $error("port hard reset left control state");
  // reading the status clears what no new event refills
  a_status_rd_clear: assert property (rd_int_sts && int_ev == '0 |=>
    int_sts_q == '0)
    else $error("status read did not clear");
  // read data stand for one cycle only
  a_rdata_one_cycle: assert property (!reg_req.rd |=> reg_rdata == 32'h00000000)
    else $error("read data outside its cycle");
  // a clear mask keeps the interrupt line low
  a_irq_masked: assert property (int_mask_q == '0 |-> !irq)
    else $error("interrupt with all sources masked");

  // main scenarios
  c_override: cover property (override_hit ##1 s5_request);
  c_sci_route: cover property (sci && !system_sleeping && pb_event);
  c_wake: cover property (wake_event);
  c_bm_clear: cover property (bm_flag_q ##1 clr_bm ##1 !bm_flag_q);
  c_release: cover property (fw_release ##1 sci);

endmodule : pm_event_status_bits

// [tb/button_partner.sv]
`timescale 1ns/1ps
// button model: contact closes the pin to ground while pressed
module button_partner (
  input wire logic clk_sys,
  input wire logic press,
  output logic power_button_input_n
);
  // pin has a pull-up, so a released button reads high once clocked
  // contact follows the press request one edge later
  always @(posedge clk_sys)
  begin
    power_button_input_n <= ~press;
  end
endmodule : button_partner

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
  // one row: bus master sources and the flag they should give
  typedef struct packed {
    logic [5:0] pci_n;
    logic [3:0] im;
    logic gfx_n;
    logic [11:0] usb;
    logic ide;
    logic [3:0] aud;
    logic bm;
  } row_s;
  logic clk_sys, rst, hard_reset_cf9, press, sleeping, btn_n, gfx_n, ide;
  logic sci, smi_n, wake, s5, wbo, irq;
  logic [5:0] pci_n;
  logic [3:0] im, aud;
  logic [31:0] rdata;
  pm_event_pkg::reg_req_s reg_req;
  pm_event_pkg::usb_status_s [2:0] usb;
  int fail_count, n_tests, s5_cnt, i;
  // usb nibble per controller: global suspend, two port suspends, run
  row_s rows [0:10] = '{
    '{6'h3f, 4'h0, 1'b1, 12'h000, 1'b0, 4'h0, 1'b0},
    '{6'h3e, 4'h0, 1'b1, 12'h000, 1'b0, 4'h0, 1'b1},
    '{6'h1f, 4'h0, 1'b1, 12'h000, 1'b0, 4'h0, 1'b1},
    '{6'h3f, 4'h8, 1'b1, 12'h000, 1'b0, 4'h0, 1'b1},
    '{6'h3f, 4'h0, 1'b0, 12'h000, 1'b0, 4'h0, 1'b1},
    '{6'h3f, 4'h0, 1'b1, 12'h001, 1'b0, 4'h0, 1'b1},
    '{6'h3f, 4'h0, 1'b1, 12'h300, 1'b0, 4'h0, 1'b1},
    '{6'h3f, 4'h0, 1'b1, 12'h090, 1'b0, 4'h0, 1'b0},
    '{6'h3f, 4'h0, 1'b1, 12'h007, 1'b0, 4'h0, 1'b0},
    '{6'h3f, 4'h0, 1'b1, 12'h000, 1'b1, 4'h0, 1'b1},
    '{6'h3f, 4'h0, 1'b1, 12'h000, 1'b0, 4'h4, 1'b1}};

  button_partner btn_u (.clk_sys(clk_sys), .press(press), .power_button_input_n(btn_n));

  // short long-press count keeps the run brief
  pm_event_status_bits #(.OVERRIDE_CYCLES(27'd20)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .hard_reset_cf9(hard_reset_cf9),
    .reg_req(reg_req), .reg_rdata(rdata), .power_button_input_n(btn_n),
    .system_sleeping(sleeping), .pci_req_n(pci_n), .internal_master_req(im),
    .graphics_port_busy_n(gfx_n), .usb_status(usb),
    .ide_bus_master_engine_start(ide), .audio_dma_run(aud), .sci(sci),
    .system_management_interrupt_n(smi_n), .wake_event(wake),
    .s5_request(s5), .wake_button_only(wbo), .irq(irq));

  // free-running system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // counts power-off pulses
  always @(posedge clk_sys)
  begin
    if (s5 === 1'b1) s5_cnt++;
  end

  task automatic wrap_up;
    $display("tests %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %0s got %h", $time, m, got);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %0s got %b", $time, m, got);
    end
  endtask : chk_bit

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    reg_req.wr <= 1'b0;
    #1;
  endtask : wr

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string m);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    reg_req.rd <= 1'b0;
    #1;
    chk_word(rdata, exp, m);
  endtask : rd_chk

  task automatic src(input row_s r);
    @(posedge clk_sys);
    pci_n <= r.pci_n;
    im <= r.im;
    gfx_n <= r.gfx_n;
    usb <= r.usb;
    ide <= r.ide;
    aud <= r.aud;
  endtask : src

  task automatic tap(input int n);
    @(posedge clk_sys);
    press <= 1'b1;
    repeat (n) @(posedge clk_sys);
    press <= 1'b0;
    cyc(6);
  endtask : tap

  // hang guard
  initial
  begin
    #2000000;
    fail_count++;
    $display("unexpected at %0t: run too long", $time);
    wrap_up();
  end

  initial
  begin
    rst = 1'b1;
    hard_reset_cf9 = 1'b0;
    press = 1'b0;
    sleeping = 1'b0;
    reg_req = '0;
    {pci_n, im, gfx_n, usb, ide, aud} = {6'h3f, 4'h0, 1'b1, 12'h000, 1'b0, 4'h0};
    fail_count = 0;
    n_tests = 0;
    s5_cnt = 0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    cyc(1);
    // reset state
    rd_chk(pm_event_pkg::OFS_FLAGS, 32'h0, "flags after reset");
    rd_chk(pm_event_pkg::OFS_ENABLE, 32'h0, "enable after reset");
    rd_chk(8'h20, 32'h0, "unmapped read");
    chk_bit(smi_n, 1'b1, "smi idle");
    chk_bit(irq, 1'b0, "irq idle");
    $display("test reset done");
    // bus master sources, table driven
    for (i = 0; i < 11; i++)
    begin
      src(rows[i]);
      cyc(4);
      src(rows[0]);
      cyc(4);
      rd_chk(pm_event_pkg::OFS_FLAGS, {27'h0, rows[i].bm, 4'h0}, "bm flag");
      chk_bit(sci | wake | ~smi_n, 1'b0, "bm raised event");
      wr(pm_event_pkg::OFS_FLAGS, 32'h10);
      rd_chk(pm_event_pkg::OFS_FLAGS, 32'h0, "bm clear");
    end
    $display("test bus master done");
    // short press, masked interrupt path
    rd_chk(pm_event_pkg::OFS_INT_STATUS, 32'h8, "int status bm");
    wr(pm_event_pkg::OFS_INT_MASK, 32'h1);
    tap(3);
    chk_bit(irq, 1'b1, "irq on press");
    rd_chk(pm_event_pkg::OFS_FLAGS, 32'h100, "pb flag set");
    chk_bit(sci | ~smi_n, 1'b0, "event while disabled");
    rd_chk(pm_event_pkg::OFS_INT_STATUS, 32'h1, "int status pb");
    chk_bit(irq, 1'b0, "irq after read clear");
    wr(pm_event_pkg::OFS_ENABLE, 32'h100);
    wr(pm_event_pkg::OFS_CONTROL, 32'h1);
    chk_bit(sci, 1'b1, "sci routed");
    wr(pm_event_pkg::OFS_CONTROL, 32'h0);
    chk_bit(sci, 1'b0, "sci with smi route");
    chk_bit(smi_n, 1'b0, "smi routed");
    @(posedge clk_sys);
    sleeping <= 1'b1;
    cyc(1);
    chk_bit(wake, 1'b1, "wake while asleep");
    chk_bit(smi_n, 1'b1, "smi while asleep");
    @(posedge clk_sys);
    sleeping <= 1'b0;
    hard_reset_cf9 <= 1'b1;
    @(posedge clk_sys);
    hard_reset_cf9 <= 1'b0;
    rd_chk(pm_event_pkg::OFS_FLAGS, 32'h100, "pb flag after port reset");
    wr(pm_event_pkg::OFS_FLAGS, 32'h0);
    rd_chk(pm_event_pkg::OFS_FLAGS, 32'h100, "write zero keeps");
    wr(pm_event_pkg::OFS_FLAGS, 32'h100);
    rd_chk(pm_event_pkg::OFS_FLAGS, 32'h0, "write one clears");
    chk_bit(smi_n, 1'b1, "smi drops with flag");
    $display("test button done");
    // firmware release and handler service
    wr(pm_event_pkg::OFS_CONTROL, 32'h2);
    rd_chk(pm_event_pkg::OFS_FLAGS, 32'h20, "attention set");
    chk_bit(sci, 1'b1, "attention sci");
    wr(pm_event_pkg::OFS_FLAGS, 32'h20);
    rd_chk(pm_event_pkg::OFS_FLAGS, 32'h0, "attention cleared");
    chk_bit(sci, 1'b0, "sci after service");
    $display("test firmware done");
    // long press: forced power off
    @(posedge clk_sys);
    press <= 1'b1;
    for (i = 0; i < 100 && s5_cnt == 0; i++) cyc(1);
    if (s5_cnt == 0)
    begin
      fail_count++;
      $display("unexpected at %0t: no power-off request", $time);
      wrap_up();
    end
    cyc(10);
    chk_bit(wbo, 1'b1, "button-only wake armed");
    @(posedge clk_sys);
    press <= 1'b0;
    cyc(6);
    rd_chk(pm_event_pkg::OFS_FLAGS, 32'h800, "override flags");
    chk_word(32'(s5_cnt), 32'h1, "single power-off pulse");
    $display("test override done");
    wrap_up();
  end
endmodule : testbench
